// [rtl/port_h_alt_map.vh]
`ifndef PORT_H_ALT_MAP_VH
`define PORT_H_ALT_MAP_VH

// ----------------------------------------------------------------
// register bus geometry
// ----------------------------------------------------------------
`define PH_ADDR_W          3
`define PH_DATA_W          8
`define PH_PINS            8
`define PH_SEG_LINES       40

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PH_REG_CTRL        3'h0
`define PH_REG_MASK        3'h1
`define PH_REG_SENSE       3'h2
`define PH_REG_STATUS      3'h3
`define PH_REG_CLEAR       3'h4
`define PH_REG_IRQ_EN      3'h5
`define PH_REG_GATE        3'h6

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define PH_CTRL_LCD_ON     0
`define PH_CTRL_LOW_POWER  1
`define PH_CTRL_GROUP0_ON  2
`define PH_CTRL_USED_W     3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PH_CTRL_RESET      3'h0
`define PH_MASK_RESET      8'h00
`define PH_STATUS_RESET    8'h00
`define PH_IRQ_EN_RESET    8'h00

// ----------------------------------------------------------------
// segment lines per pin
// ----------------------------------------------------------------
`define PH_SEG_PIN7        36
`define PH_SEG_PIN6        37
`define PH_SEG_PIN5        38
`define PH_SEG_PIN4        39
`define PH_SEG_PIN3        7
`define PH_SEG_PIN2        8
`define PH_SEG_PIN1        9
`define PH_SEG_PIN0        10

// ----------------------------------------------------------------
// fixed override values
// ----------------------------------------------------------------
`define PH_PULLUP_OVR_VAL  8'h00
`define PH_DIR_OVR_VAL     8'h00
`define PH_OUTVAL_OVR_ON   8'h00
`define PH_OUTVAL_OVR_VAL  8'h00
`define PH_GATE_OVR_VAL    8'h00

`endif

// [rtl/pin_level_sync.v]
// ----------------------------------------------------------------
// two-stage synchroniser for the pad levels
// ----------------------------------------------------------------
module pin_level_sync #(
    parameter WIDTH = 8
) (
    input  wire             core_clk_in,
    input  wire             rstn_in,
    input  wire [WIDTH-1:0] level_in,
    output wire [WIDTH-1:0] level_out
);

    reg [WIDTH-1:0] stage_one;
    reg [WIDTH-1:0] stage_two;

    genvar i;

    // one flop pair per pin; only stage_two may be read outside
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_sync
            always @(posedge core_clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    stage_one[i] <= 1'b0;
                    stage_two[i] <= 1'b0;
                end else begin
                    stage_one[i] <= level_in[i];
                    stage_two[i] <= stage_one[i];
                end
            end
        end
    endgenerate

    assign level_out = stage_two;

endmodule // pin_level_sync

// [rtl/port_h_alt_function_override.v]
// Behaviour
// - pins 7..0 feed pin-change interrupt sources 23..16 in order
// - pins 7,6,5,4 carry LCD front-plane lines 36,37,38,39 when LCD drives
// - pins 3,2,1,0 carry LCD front-plane lines 7,8,9,10 when LCD drives
// - pull-up forced off while LCD enabled; output value never overridden
// - direction forced to input while LCD enabled, else direction register
// - input gate override needs mask bit, group 0, LCD on and low power
// - synchronised pin sense feeds each pin-change source, even under LCD
// - LCD segment drive reaches each pin's analog path when LCD enabled
`include "port_h_alt_map.vh"

module port_h_alt_function_override (
    input  wire                      core_clk_in,
    input  wire                      rstn_in,
    // register port
    input  wire [`PH_ADDR_W-1:0]     reg_addr_in,
    input  wire [`PH_DATA_W-1:0]     reg_wdata_in,
    input  wire                      reg_wr_in,
    input  wire                      reg_rd_in,
    output reg  [`PH_DATA_W-1:0]     reg_rdata_out,
    // pad and port side
    input  wire [`PH_PINS-1:0]       pad_level_in,
    input  wire [`PH_PINS-1:0]       dir_reg_in,
    input  wire [`PH_SEG_LINES-1:0]  plane_drive_signal_in,
    // overrides towards the generic port logic
    output reg  [`PH_PINS-1:0]       pullup_override_on_out,
    output reg  [`PH_PINS-1:0]       pullup_override_val_out,
    output reg  [`PH_PINS-1:0]       direction_override_on_out,
    output reg  [`PH_PINS-1:0]       direction_override_val_out,
    output reg  [`PH_PINS-1:0]       outval_override_on_out,
    output reg  [`PH_PINS-1:0]       outval_override_val_out,
    output reg  [`PH_PINS-1:0]       input_gate_override_on_out,
    output reg  [`PH_PINS-1:0]       input_gate_override_val_out,
    output reg  [`PH_PINS-1:0]       dir_effective_out,
    output reg  [`PH_PINS-1:0]       pin_sense_path_out,
    output reg  [`PH_PINS-1:0]       analog_pad_path_out,
    // pin-change interrupt sources
    output wire                      change_irq_src_23_out,
    output wire                      change_irq_src_22_out,
    output wire                      change_irq_src_21_out,
    output wire                      change_irq_src_20_out,
    output wire                      change_irq_src_19_out,
    output wire                      change_irq_src_18_out,
    output wire                      change_irq_src_17_out,
    output wire                      change_irq_src_16_out,
    // interrupt
    output wire                      irq_out
);

    // ----------------------------------------------------------------
    // address decode helper
    // ----------------------------------------------------------------
    function addr_is;
        input [`PH_ADDR_W-1:0] addr;
        input [`PH_ADDR_W-1:0] offset;
        begin
            addr_is = (addr == offset);
        end
    endfunction

    // segment line carried by each pin
    function integer seg_for_pin;
        input integer pin;
        begin
            case (pin)
                7:       seg_for_pin = `PH_SEG_PIN7;
                6:       seg_for_pin = `PH_SEG_PIN6;
                5:       seg_for_pin = `PH_SEG_PIN5;
                4:       seg_for_pin = `PH_SEG_PIN4;
                3:       seg_for_pin = `PH_SEG_PIN3;
                2:       seg_for_pin = `PH_SEG_PIN2;
                1:       seg_for_pin = `PH_SEG_PIN1;
                default: seg_for_pin = `PH_SEG_PIN0;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    reg  [`PH_CTRL_USED_W-1:0] ctrl;
    reg  [`PH_PINS-1:0]        change_mask;
    reg  [`PH_PINS-1:0]        change_status;
    reg  [`PH_PINS-1:0]        irq_enable;
    reg  [`PH_PINS-1:0]        sense_prev;
    reg  [`PH_DATA_W-1:0]      next_rdata;
    reg  [`PH_PINS-1:0]        next_status;

    wire [`PH_PINS-1:0]        sense_sync;
    wire [`PH_PINS-1:0]        seg_pick;
    wire [`PH_PINS-1:0]        gate_on;
    wire [`PH_PINS-1:0]        change_event;
    wire                       lcd_ctrl_on;
    wire                       lcd_low_power_sel;
    wire                       change_irq_group0_on;
    wire                       wr_ctrl;
    wire                       wr_mask;
    wire                       wr_clear;
    wire                       wr_irq_en;

    // ----------------------------------------------------------------
    // control fields
    // ----------------------------------------------------------------
    assign lcd_ctrl_on          = ctrl[`PH_CTRL_LCD_ON];
    assign lcd_low_power_sel    = ctrl[`PH_CTRL_LOW_POWER];
    assign change_irq_group0_on = ctrl[`PH_CTRL_GROUP0_ON];

    // write decode; strobes are single cycle so no edge detect needed
    assign wr_ctrl   = reg_wr_in && addr_is(reg_addr_in, `PH_REG_CTRL);
    assign wr_mask   = reg_wr_in && addr_is(reg_addr_in, `PH_REG_MASK);
    assign wr_clear  = reg_wr_in && addr_is(reg_addr_in, `PH_REG_CLEAR);
    assign wr_irq_en = reg_wr_in && addr_is(reg_addr_in, `PH_REG_IRQ_EN);

    // ----------------------------------------------------------------
    // pad synchronisation
    // ----------------------------------------------------------------
    // pads are asynchronous to the core, so nothing reads them raw
    pin_level_sync #(
        .WIDTH      (`PH_PINS)
    ) u_sync (
        .core_clk_in (core_clk_in),
        .rstn_in     (rstn_in),
        .level_in    (pad_level_in),
        .level_out   (sense_sync)
    );

    // ----------------------------------------------------------------
    // per-pin segment selection and gate condition
    // ----------------------------------------------------------------
    genvar p;
    generate
        for (p = 0; p < `PH_PINS; p = p + 1) begin : g_pin
            // fixed line per pin; upper and lower halves use different banks
            assign seg_pick[p] = plane_drive_signal_in[seg_for_pin(p)];
            // all four terms must hold at once
            assign gate_on[p]  = change_mask[p] & change_irq_group0_on
                               & lcd_ctrl_on & lcd_low_power_sel;
        end
    endgenerate

    // a change on a masked synchronised level counts while group 0 is on, whatever drives the pin
    assign change_event = (sense_sync ^ sense_prev) & change_mask
                        & {`PH_PINS{change_irq_group0_on}};

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl        <= `PH_CTRL_RESET;
            change_mask <= `PH_MASK_RESET;
            irq_enable  <= `PH_IRQ_EN_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl <= reg_wdata_in[`PH_CTRL_USED_W-1:0];
            end
            if (wr_mask) begin
                change_mask <= reg_wdata_in[`PH_PINS-1:0];
            end
            if (wr_irq_en) begin
                irq_enable <= reg_wdata_in[`PH_PINS-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // sticky change status
    // ----------------------------------------------------------------
    // a new event in the clear cycle survives: set is applied last
    always @* begin
        next_status = change_status;
        if (wr_clear) begin
            next_status = next_status & ~reg_wdata_in[`PH_PINS-1:0];
        end
        next_status = next_status | change_event;
    end

    always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            change_status <= `PH_STATUS_RESET;
            sense_prev    <= {`PH_PINS{1'b0}};
        end else begin
            change_status <= next_status;
            sense_prev    <= sense_sync;
        end
    end

    // level interrupt, high while any enabled status bit is set
    assign irq_out = |(change_status & irq_enable);

    // ----------------------------------------------------------------
    // override outputs
    // ----------------------------------------------------------------
    // registered so the port logic sees glitch-free overrides; costs one cycle
    always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pullup_override_on_out      <= {`PH_PINS{1'b0}};
            pullup_override_val_out     <= `PH_PULLUP_OVR_VAL;
            direction_override_on_out   <= {`PH_PINS{1'b0}};
            direction_override_val_out  <= `PH_DIR_OVR_VAL;
            outval_override_on_out      <= `PH_OUTVAL_OVR_ON;
            outval_override_val_out     <= `PH_OUTVAL_OVR_VAL;
            input_gate_override_on_out  <= {`PH_PINS{1'b0}};
            input_gate_override_val_out <= `PH_GATE_OVR_VAL;
            dir_effective_out           <= {`PH_PINS{1'b0}};
        end else begin
            pullup_override_on_out      <= {`PH_PINS{lcd_ctrl_on}};
            pullup_override_val_out     <= `PH_PULLUP_OVR_VAL;
            outval_override_on_out      <= `PH_OUTVAL_OVR_ON;
            outval_override_val_out     <= `PH_OUTVAL_OVR_VAL;
            direction_override_on_out   <= {`PH_PINS{lcd_ctrl_on}};
            direction_override_val_out  <= `PH_DIR_OVR_VAL;
            // override to input under LCD, otherwise the register decides
            dir_effective_out           <= lcd_ctrl_on ? `PH_DIR_OVR_VAL
                                                       : dir_reg_in;
            input_gate_override_on_out  <= gate_on;
            // only the disabled value is ever offered
            input_gate_override_val_out <= `PH_GATE_OVR_VAL;
        end
    end

    // ----------------------------------------------------------------
    // sense and analog paths
    // ----------------------------------------------------------------
    // sense path is never gated so changes stay visible under LCD drive
    always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pin_sense_path_out  <= {`PH_PINS{1'b0}};
            analog_pad_path_out <= {`PH_PINS{1'b0}};
        end else begin
            pin_sense_path_out  <= sense_sync;
            analog_pad_path_out <= seg_pick & {`PH_PINS{lcd_ctrl_on}};
        end
    end

    // ----------------------------------------------------------------
    // pin-change source fan-out
    // ----------------------------------------------------------------
    assign change_irq_src_23_out = pin_sense_path_out[7];
    assign change_irq_src_22_out = pin_sense_path_out[6];
    assign change_irq_src_21_out = pin_sense_path_out[5];
    assign change_irq_src_20_out = pin_sense_path_out[4];
    assign change_irq_src_19_out = pin_sense_path_out[3];
    assign change_irq_src_18_out = pin_sense_path_out[2];
    assign change_irq_src_17_out = pin_sense_path_out[1];
    assign change_irq_src_16_out = pin_sense_path_out[0];

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // unmapped and write-only offsets read as zero
    always @* begin
        next_rdata = {`PH_DATA_W{1'b0}};
        if (reg_rd_in) begin
            case (reg_addr_in)
                `PH_REG_CTRL:   next_rdata = {{(`PH_DATA_W-`PH_CTRL_USED_W){1'b0}}, ctrl};
                `PH_REG_MASK:   next_rdata = change_mask;
                `PH_REG_SENSE:  next_rdata = sense_sync;
                `PH_REG_STATUS: next_rdata = change_status;
                `PH_REG_IRQ_EN: next_rdata = irq_enable;
                `PH_REG_GATE:   next_rdata = gate_on;
                default:        next_rdata = {`PH_DATA_W{1'b0}};
            endcase
        end
    end

    // data stands only in the cycle after the read strobe
    always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            reg_rdata_out <= {`PH_DATA_W{1'b0}};
        end else begin
            reg_rdata_out <= next_rdata;
        end
    end

endmodule // port_h_alt_function_override

// [verification/port_h_alt_props.sv]
`include "port_h_alt_map.vh"
// ----------------------------------------------------------------
// port-level properties of the override block
// ----------------------------------------------------------------
module port_h_alt_props (
    input logic                     core_clk_in,
    input logic                     rstn_in,
    input logic                     reg_rd_in,
    input logic [`PH_DATA_W-1:0]    reg_rdata_out,
    input logic [`PH_PINS-1:0]      pad_level_in,
    input logic [`PH_PINS-1:0]      dir_reg_in,
    input logic [`PH_SEG_LINES-1:0] plane_drive_signal_in,
    input logic [`PH_PINS-1:0]      pullup_override_on_out,
    input logic [`PH_PINS-1:0]      pullup_override_val_out,
    input logic [`PH_PINS-1:0]      direction_override_on_out,
    input logic [`PH_PINS-1:0]      direction_override_val_out,
    input logic [`PH_PINS-1:0]      outval_override_on_out,
    input logic [`PH_PINS-1:0]      outval_override_val_out,
    input logic [`PH_PINS-1:0]      input_gate_override_on_out,
    input logic [`PH_PINS-1:0]      input_gate_override_val_out,
    input logic [`PH_PINS-1:0]      dir_effective_out,
    input logic [`PH_PINS-1:0]      pin_sense_path_out,
    input logic [`PH_PINS-1:0]      analog_pad_path_out,
    input logic                     change_irq_src_23_out,
    input logic                     change_irq_src_22_out,
    input logic                     change_irq_src_21_out,
    input logic                     change_irq_src_20_out,
    input logic                     change_irq_src_19_out,
    input logic                     change_irq_src_18_out,
    input logic                     change_irq_src_17_out,
    input logic                     change_irq_src_16_out,
    input logic                     irq_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    // source bits in pin order, segment lines in the order the pins carry them
    wire [7:0] src_vec = {change_irq_src_23_out, change_irq_src_22_out, change_irq_src_21_out, change_irq_src_20_out,
                          change_irq_src_19_out, change_irq_src_18_out, change_irq_src_17_out, change_irq_src_16_out};
    wire [7:0] seg_vec = {plane_drive_signal_in[36], plane_drive_signal_in[37], plane_drive_signal_in[38],
                          plane_drive_signal_in[39], plane_drive_signal_in[7], plane_drive_signal_in[8],
                          plane_drive_signal_in[9], plane_drive_signal_in[10]};
    property p_pullup_off; pullup_override_on_out inside {8'h00, 8'hff} && !pullup_override_val_out; endproperty
    a_pullup_off: assert property (p_pullup_off) else $error("pull-up override not uniform off");
    property p_outval_free; outval_override_on_out == 8'h00 && outval_override_val_out == 8'h00; endproperty
    a_outval_free: assert property (p_outval_free) else $error("output value overridden");
    property p_dir_input; direction_override_on_out == pullup_override_on_out && direction_override_val_out == 8'h00;
    endproperty
    a_dir_input: assert property (p_dir_input) else $error("direction override not input with lcd");
    // the guard skips the first edge after reset, where the register still holds its reset value
    property p_dir_seen; $past(rstn_in) |-> dir_effective_out ==
        (direction_override_on_out[0] ? 8'h00 : $past(dir_reg_in)); endproperty
    a_dir_seen: assert property (p_dir_seen) else $error("effective direction wrong");
    property p_gate_cause; |input_gate_override_on_out |-> direction_override_on_out == 8'hff; endproperty
    a_gate_cause: assert property (p_gate_cause) else $error("gate override without lcd");
    property p_gate_val; input_gate_override_val_out == 8'h00; endproperty
    a_gate_val: assert property (p_gate_val) else $error("gate override value not disabled");
    property p_analog; $past(rstn_in) |-> analog_pad_path_out == (pullup_override_on_out[0] ? $past(seg_vec) : 8'h00);
    endproperty
    a_analog: assert property (p_analog) else $error("analog path segment mapping wrong");
    property p_src_map; src_vec == pin_sense_path_out; endproperty
    a_src_map: assert property (p_src_map) else $error("change source order wrong");
    property p_sense; $past(rstn_in, 3) && $past(rstn_in, 2) && $past(rstn_in)
        |-> pin_sense_path_out == $past(pad_level_in, 3); endproperty
    a_sense: assert property (p_sense) else $error("sense path latency wrong");
    property p_rd_stand; reg_rdata_out != 8'h00 |-> $past(reg_rd_in); endproperty
    a_rd_stand: assert property (p_rd_stand) else $error("read data outside its cycle");
    c_gate: cover property (|input_gate_override_on_out);
    c_irq: cover property (irq_out);
    c_lcd_off: cover property (pullup_override_on_out == 8'hff ##1 pullup_override_on_out == 8'h00);
endmodule // port_h_alt_props

bind port_h_alt_function_override port_h_alt_props u_port_h_alt_props (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .pad_level_in(pad_level_in), .dir_reg_in(dir_reg_in), .plane_drive_signal_in(plane_drive_signal_in),
    .pullup_override_on_out(pullup_override_on_out), .pullup_override_val_out(pullup_override_val_out),
    .direction_override_on_out(direction_override_on_out), .direction_override_val_out(direction_override_val_out),
    .outval_override_on_out(outval_override_on_out), .outval_override_val_out(outval_override_val_out),
    .input_gate_override_on_out(input_gate_override_on_out), .input_gate_override_val_out(input_gate_override_val_out),
    .dir_effective_out(dir_effective_out), .pin_sense_path_out(pin_sense_path_out),
    .analog_pad_path_out(analog_pad_path_out), .change_irq_src_23_out(change_irq_src_23_out),
    .change_irq_src_22_out(change_irq_src_22_out), .change_irq_src_21_out(change_irq_src_21_out),
    .change_irq_src_20_out(change_irq_src_20_out), .change_irq_src_19_out(change_irq_src_19_out),
    .change_irq_src_18_out(change_irq_src_18_out), .change_irq_src_17_out(change_irq_src_17_out),
    .change_irq_src_16_out(change_irq_src_16_out), .irq_out(irq_out));

// [verification/lcd_glass_pads.sv]
// ----------------------------------------------------------------
// far-side pads: return the commanded level, promptly or one clock late
// ----------------------------------------------------------------
module lcd_glass_pads (
    input  logic       core_clk_in,
    input  logic [7:0] level_cmd_in,
    input  logic       slow_in,
    output logic [7:0] pad_level_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] late;
    // a heavily loaded glass line settles late, so the sense path must not rely on prompt pads
    always @(posedge core_clk_in) late <= level_cmd_in;
    assign pad_level_out = slow_in ? late : level_cmd_in;
endmodule // lcd_glass_pads

// [verification/test_port_h_alt_function_override.sv]
`include "port_h_alt_map.vh"
module test_port_h_alt_function_override;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rstn, wr, rd, slow, irq;
    logic [2:0]  addr;
    logic [7:0]  wdata, rdata, dir_reg, pad_cmd, pad, pu_on, pu_val, dd_on, dd_val, pv_on, pv_val;
    logic [7:0]  ig_on, ig_val, dir_eff, sense, analog;
    logic [39:0] plane;
    logic [31:0] seed = 32'd75829;
    logic [7:0]  exp_q[$];
    logic        rd_pending = 1'b0;
    int          miscompares = 0;
    int          checks = 0;
    int          cycles = 0;
    wire  [7:0]  src;
    port_h_alt_function_override u_port_h_alt_function_override (
        .core_clk_in(clk), .rstn_in(rstn), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .pad_level_in(pad), .dir_reg_in(dir_reg), .plane_drive_signal_in(plane),
        .pullup_override_on_out(pu_on), .pullup_override_val_out(pu_val), .direction_override_on_out(dd_on),
        .direction_override_val_out(dd_val), .outval_override_on_out(pv_on), .outval_override_val_out(pv_val),
        .input_gate_override_on_out(ig_on), .input_gate_override_val_out(ig_val), .dir_effective_out(dir_eff),
        .pin_sense_path_out(sense), .analog_pad_path_out(analog), .change_irq_src_23_out(src[7]),
        .change_irq_src_22_out(src[6]), .change_irq_src_21_out(src[5]), .change_irq_src_20_out(src[4]),
        .change_irq_src_19_out(src[3]), .change_irq_src_18_out(src[2]), .change_irq_src_17_out(src[1]),
        .change_irq_src_16_out(src[0]), .irq_out(irq));
    lcd_glass_pads u_lcd_glass_pads (.core_clk_in(clk), .level_cmd_in(pad_cmd), .slow_in(slow), .pad_level_out(pad));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic next_rand(output logic [7:0] v);
        repeat (8) seed = lfsr(seed);
        v = seed[7:0];
    endtask
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] expv);
        checks++;
        if (seen !== expv) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, expv, seen);
        end
    endtask
    // strobes stay up until the next task or idle; each task sets both strobes, so back-to-back calls need no idle between them
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        rd <= 1'b0;
    endtask
    task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        wr <= 1'b0;
        exp_q.push_back(e);
    endtask
    task automatic idle(input int n);
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic print_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // read data stands only in the cycle after the strobe: check the oldest note there, zero elsewhere
    always @(negedge clk) begin
        if (rd_pending) chk("read data", rdata, exp_q.pop_front());
        else chk("idle read data", rdata, 8'h00);
        rd_pending = rd;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            $display("[ERR] run length expected finish seen hang");
            print_verdict();
        end
    end

    initial begin
        logic [7:0] m, v;
        logic       lcd;
        rstn = 1'b0; wr = 1'b0; rd = 1'b0; addr = 3'h0; wdata = 8'h00;
        dir_reg = 8'h00; pad_cmd = 8'h00; plane = 40'h00; slow = 1'b0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        idle(2);
        // reset values of every offset, the unmapped one included
        for (int a = 0; a < 8; a++) rd_reg(a[2:0], 8'h00);
        next_rand(m);
        wr_reg(`PH_REG_MASK, m);
        wr_reg(`PH_REG_IRQ_EN, ~m);
        wr_reg(`PH_REG_STATUS, 8'hff);
        rd_reg(`PH_REG_MASK, m);
        rd_reg(`PH_REG_IRQ_EN, ~m);
        rd_reg(`PH_REG_STATUS, 8'h00);
        wr_reg(`PH_REG_CTRL, 8'hff);
        rd_reg(`PH_REG_CTRL, 8'h07);
        // every control combination, with fresh direction and segment drive each time
        for (int c = 0; c < 8; c++) begin
            next_rand(v);
            dir_reg <= v;
            plane <= {seed, v};
            wr_reg(`PH_REG_CTRL, c[7:0]);
            idle(3);
            lcd = c[0];
            chk("pull-up on", pu_on, {8{lcd}});
            chk("pull-up value", pu_val, 8'h00);
            chk("output value on", pv_on, 8'h00);
            chk("output value", pv_val, 8'h00);
            chk("direction on", dd_on, {8{lcd}});
            chk("direction value", dd_val, 8'h00);
            chk("effective direction", dir_eff, lcd ? 8'h00 : v);
            chk("gate on", ig_on, (c == 7) ? m : 8'h00);
            chk("gate value", ig_val, 8'h00);
            chk("analog path", analog, lcd ? {plane[36], plane[37], plane[38], plane[39],
                plane[7], plane[8], plane[9], plane[10]} : 8'h00);
            rd_reg(`PH_REG_GATE, (c == 7) ? m : 8'h00);
        end
        // pin change with lcd off: only masked pins raise status, irq follows enable
        wr_reg(`PH_REG_CTRL, 8'h04);
        wr_reg(`PH_REG_MASK, 8'h0f);
        wr_reg(`PH_REG_IRQ_EN, 8'hff);
        idle(1);
        next_rand(v);
        v = v | 8'h11;
        pad_cmd <= v;
        idle(5);
        chk("sense path", sense, v);
        chk("change sources", src, v);
        chk("irq raised", {7'h00, irq}, 8'h01);
        rd_reg(`PH_REG_STATUS, v & 8'h0f);
        rd_reg(`PH_REG_SENSE, v);
        wr_reg(`PH_REG_IRQ_EN, 8'h00);
        idle(2);
        chk("irq masked", {7'h00, irq}, 8'h00);
        wr_reg(`PH_REG_CLEAR, 8'hff);
        rd_reg(`PH_REG_STATUS, 8'h00);
        // under lcd drive with a slow pad the change must still be sensed
        slow <= 1'b1;
        wr_reg(`PH_REG_CTRL, 8'h07);
        idle(1);
        pad_cmd <= ~v;
        idle(6);
        chk("sense under lcd", sense, ~v);
        chk("sources under lcd", src, ~v);
        rd_reg(`PH_REG_STATUS, 8'h0f);
        idle(3);
        print_verdict();
    end
endmodule // test_port_h_alt_function_override
